// ---- pkg/acs_pkg.sv ----
// Constants and types shared by the conversion sequencer.
// Assumes one core clock at 100 MHz and a synchronous active-high reset.
package acs_pkg;
	// Core clock rate
	localparam int CORE_CLK_MHZ    = 100;
	// Conversion lengths in converter clocks
	localparam int NORMAL_CONV_CYC = 13;
	localparam int FIRST_CONV_CYC  = 25;
	localparam int AUTO_CONV_CYC   = 14;
	// Sample points in half converter clocks
	localparam int NORMAL_SAMPLE_H = 3;
	localparam int FIRST_SAMPLE_H  = 27;
	localparam int AUTO_SAMPLE_H   = 4;
	// Trigger input to start bit delay in core cycles
	localparam int TRIG_SYNC_CYC   = 3;
	// Reset values of the live selections, and the trigger source code for free running
	localparam logic [3:0] CHANNEL_RST   = 4'h0;
	localparam logic [1:0] REFERENCE_RST = 2'h0;
	localparam logic [2:0] TRIG_FREE_RUN = 3'h0;
	// Sequencer states
	typedef enum logic [1:0] {
		ACS_IDLE = 2'b00,
		ACS_CONV = 2'b01
	} acs_state_t;
endpackage

// ---- rtl/acs_sequencer.sv ----
// Conversion sequencer: prescaler, start logic, timing, selection buffer, result store.
// Assumes the analog array delivers its code on analog_result when sample and finish strobes fire.
`timescale 1ns/1ps

// Summary of operation
// - Start only when power-off bit is clear
// - Start bit held high, cleared at end
// - Channel change waits for running conversion
// - Trigger rising edge resets prescaler, starts
// - Held trigger or busy edges start nothing
// - Free run restarts without flag clearing
// - Done-flag source runs conversions back to back
// - Start bit works with auto; reads busy
// - Prescaler runs while enabled, else reset
// - Software start at next converter clock edge
// - Thirteen cycles, first after enable twenty-five
// - Sample at 1.5 or 13.5 cycles
// - End writes result, flag, clears start
// - Auto conversion samples at 2, 13.5 long
// - Free run restarts immediately, start stays high
// - Selections frozen during conversion except last clock, copied otherwise
// - Free-run change applies one conversion later
// - Selections take effect only when enabled
// - Result right aligned, left on request
// - Low read blocks updates until high read
module acs_sequencer
	import acs_pkg::*;
(
	input  wire logic       core_clk,
	input  wire logic       srst,
	input  wire logic       converter_power_off,
	input  wire logic       converter_enable,
	input  wire logic       auto_trigger_enable,
	input  wire logic [2:0] trigger_source_select,
	input  wire logic [7:0] trigger_inputs,
	input  wire logic [2:0] prescale_select,
	input  wire logic       start_write,
	input  wire logic       done_flag_clear,
	input  wire logic [3:0] channel_select,
	input  wire logic [1:0] reference_select,
	input  wire logic       left_align_result,
	input  wire logic       low_byte_read,
	input  wire logic       high_byte_read,
	input  wire logic [9:0] analog_result,
	output logic            start_conversion_bit,
	output logic            conversion_done_flag,
	output logic [7:0]      result_low_byte,
	output logic [7:0]      result_high_byte,
	output logic [3:0]      active_channel,
	output logic [1:0]      active_reference,
	output logic            sample_hold,
	output logic            analog_enable
);
	// Registers
	logic [6:0] presc_ff;                  // Core-cycle prescaler
	logic [7:0] trig_s1_ff, trig_s2_ff;    // Trigger synchroniser
	logic       trig_sel_ff;               // Edge detector history
	logic       busy_ff;                   // Conversion running
	logic       first_ff;                  // Next conversion is first after enable
	logic       auto_ff;                   // Running conversion was triggered
	logic       pend_ff;                   // Software start awaiting clock edge
	logic [5:0] half_ff;                   // Half converter clocks into conversion
	logic       flag_ff;                   // Completion flag
	logic       lock_ff;                   // Data registers blocked
	logic [9:0] data_ff;                   // Stored result
	logic [3:0] chan_ff;
	logic [1:0] ref_ff;
	logic       samp_ff;

	// Divider select: power-of-two factor 2..128
	function automatic logic [6:0] div_mask(input logic [2:0] sel);
		div_mask = (sel == 3'h0) ? 7'h01 : 7'((8'h01 << sel) - 8'h01);
	endfunction

	wire [6:0] mask      = div_mask(prescale_select);
	wire [6:0] half_mask = 7'(mask >> 1);
	wire       trig_raw  = trig_s2_ff[trigger_source_select];
	wire       trig_rise = trig_raw & ~trig_sel_ff;
	wire       free_run  = auto_trigger_enable & (trigger_source_select == TRIG_FREE_RUN);
	wire       usable    = converter_enable & ~converter_power_off;
	// Half-clock tick: mid and end of each converter clock
	wire       tick_end  = (presc_ff == mask);
	wire       tick_mid  = (presc_ff == half_mask);
	wire       half_tick = tick_end | tick_mid;
	// Trigger start, masked while busy; free-run source never starts from an edge
	wire       auto_go   = usable & auto_trigger_enable & ~free_run & ~busy_ff & trig_rise;
	wire       sw_go     = usable & ~busy_ff & pend_ff & tick_end;
	wire [5:0] len_h     = first_ff ? 6'(2 * FIRST_CONV_CYC) :
	                       (auto_ff ? 6'(2 * AUTO_CONV_CYC - 1) : 6'(2 * NORMAL_CONV_CYC));
	wire [5:0] samp_h    = first_ff ? 6'(FIRST_SAMPLE_H) :
	                       (auto_ff ? 6'(AUTO_SAMPLE_H) : 6'(NORMAL_SAMPLE_H));
	wire       finish    = busy_ff & half_tick & (half_ff == len_h - 6'd1);
	wire       last_clk  = busy_ff & (half_ff >= len_h - 6'd2);
	wire       restart   = finish & free_run & usable;

	// Prescaler: held while disabled, reset by triggers
	always_ff @(posedge core_clk) begin
		if (srst || !converter_enable || auto_go)
			presc_ff <= 7'h00;
		else
			presc_ff <= tick_end ? 7'h00 : 7'(presc_ff + 7'h01);
	end

	// Trigger synchroniser: first stage read only by second
	always_ff @(posedge core_clk) begin
		if (srst) begin
			trig_s1_ff  <= 8'h00;
			trig_s2_ff  <= 8'h00;
			trig_sel_ff <= 1'b0;
		end else begin
			trig_s1_ff  <= trigger_inputs;
			trig_s2_ff  <= trig_s1_ff;
			trig_sel_ff <= trig_raw;
		end
	end

	// Software start request, waiting for converter clock edge
	// Any start consumes the request, so a late write cannot queue a second run
	always_ff @(posedge core_clk) begin
		if (srst || !usable)
			pend_ff <= 1'b0;
		else if (sw_go || auto_go)
			pend_ff <= 1'b0;
		else if (start_write && !busy_ff)
			pend_ff <= 1'b1;
	end

	// Conversion state and timing
	always_ff @(posedge core_clk) begin
		if (srst || !usable) begin
			busy_ff  <= 1'b0;
			half_ff  <= 6'h00;
			auto_ff  <= 1'b0;
			first_ff <= 1'b1;
		end else if (sw_go || auto_go) begin
			busy_ff <= 1'b1;
			half_ff <= 6'h00;
			auto_ff <= auto_go;
		end else if (finish) begin
			busy_ff  <= restart;
			half_ff  <= 6'h00;
			auto_ff  <= 1'b0;
			first_ff <= 1'b0;
		end else if (busy_ff && half_tick)
			half_ff <= 6'(half_ff + 6'h01);
	end

	// Sample strobe at the sample point
	always_ff @(posedge core_clk) begin
		if (srst)
			samp_ff <= 1'b0;
		else
			samp_ff <= busy_ff & half_tick & (half_ff == samp_h - 6'd1);
	end

	// Selection buffer: copied when idle or in last clock
	always_ff @(posedge core_clk) begin
		if (srst) begin
			chan_ff <= CHANNEL_RST;
			ref_ff  <= REFERENCE_RST;
		end else if (converter_enable && (!busy_ff || last_clk)) begin
			chan_ff <= channel_select;
			ref_ff  <= reference_select;
		end
	end

	// Completion flag: set wins over clear
	always_ff @(posedge core_clk) begin
		if (srst)
			flag_ff <= 1'b0;
		else if (finish)
			flag_ff <= 1'b1;
		else if (done_flag_clear)
			flag_ff <= 1'b0;
	end

	// Data lock between low and high byte reads
	always_ff @(posedge core_clk) begin
		if (srst)
			lock_ff <= 1'b0;
		else if (high_byte_read)
			lock_ff <= 1'b0;
		else if (low_byte_read)
			lock_ff <= 1'b1;
	end

	// Result store
	always_ff @(posedge core_clk) begin
		if (srst)
			data_ff <= 10'h000;
		else if (finish && !lock_ff)
			data_ff <= analog_result;
	end

	// Outputs; alignment applied on read path
	wire [15:0] shown = left_align_result ? {data_ff, 6'h00} : {6'h00, data_ff};
	assign start_conversion_bit = busy_ff | pend_ff;
	assign conversion_done_flag = flag_ff;
	assign result_low_byte      = shown[7:0];
	assign result_high_byte     = shown[15:8];
	assign active_channel       = chan_ff;
	assign active_reference     = ref_ff;
	assign sample_hold          = samp_ff;
	assign analog_enable        = usable;

	// Start bit falls when conversion ends in single mode
	property p_start_clears;
		@(posedge core_clk) disable iff (srst)
		(finish && !restart && !start_write) |=> !start_conversion_bit;
	endproperty
	a_start_clears: assert property (p_start_clears) else $error("start bit not cleared");

	property p_flag_on_finish;
		@(posedge core_clk) disable iff (srst) finish |=> conversion_done_flag;
	endproperty
	a_flag_on_finish: assert property (p_flag_on_finish) else $error("flag not set");

	property p_no_start_powered_off;
		@(posedge core_clk) disable iff (srst) converter_power_off |=> !busy_ff;
	endproperty
	a_no_start_powered_off: assert property (p_no_start_powered_off) else $error("ran while off");

	property p_presc_held;
		@(posedge core_clk) disable iff (srst) !converter_enable |=> presc_ff == 7'h00;
	endproperty
	a_presc_held: assert property (p_presc_held) else $error("prescaler ran");

	property p_sel_frozen;
		@(posedge core_clk) disable iff (srst)
		(busy_ff && !last_clk && $past(busy_ff) && !$past(last_clk)) |-> $stable(active_channel);
	endproperty
	a_sel_frozen: assert property (p_sel_frozen) else $error("channel moved mid conversion");

	property p_free_run;
		@(posedge core_clk) disable iff (srst) restart |=> busy_ff;
	endproperty
	a_free_run: assert property (p_free_run) else $error("free run stopped");

	property p_busy_reads;
		@(posedge core_clk) disable iff (srst) busy_ff |-> start_conversion_bit;
	endproperty
	a_busy_reads: assert property (p_busy_reads) else $error("start bit low while busy");

	property p_lock;
		@(posedge core_clk) disable iff (srst) (lock_ff && !high_byte_read) |=> $stable(data_ff);
	endproperty
	a_lock: assert property (p_lock) else $error("data changed while locked");

	property p_auto_presc;
		@(posedge core_clk) disable iff (srst) auto_go |=> presc_ff == 7'h00;
	endproperty
	a_auto_presc: assert property (p_auto_presc) else $error("trigger kept prescaler");

	// Software starts only on a converter clock edge, triggers anywhere
	property p_sw_start_on_tick;
		@(posedge core_clk) disable iff (srst) (!busy_ff && !tick_end && !auto_go) |=> !busy_ff;
	endproperty
	a_sw_start_on_tick: assert property (p_sw_start_on_tick) else $error("start off clock edge");

	// Sample strobe at 1.5 converter clocks for a normal run
	property p_normal_sample;
		@(posedge core_clk) disable iff (srst)
		(busy_ff && !first_ff && !auto_ff && half_tick && half_ff == 6'(NORMAL_SAMPLE_H - 1)) |=> sample_hold;
	endproperty
	a_normal_sample: assert property (p_normal_sample) else $error("normal sample missed");

	// Sample strobe at 13.5 converter clocks after enable
	property p_first_sample;
		@(posedge core_clk) disable iff (srst)
		(busy_ff && first_ff && half_tick && half_ff == 6'(FIRST_SAMPLE_H - 1)) |=> sample_hold;
	endproperty
	a_first_sample: assert property (p_first_sample) else $error("first sample missed");

	// Conversion lengths counted in half converter clocks
	property p_first_len;
		@(posedge core_clk) disable iff (srst) (finish && first_ff) |-> half_ff == 6'(2 * FIRST_CONV_CYC - 1);
	endproperty
	a_first_len: assert property (p_first_len) else $error("first conversion length");

	property p_normal_len;
		@(posedge core_clk) disable iff (srst)
		(finish && !first_ff && !auto_ff) |-> half_ff == 6'(2 * NORMAL_CONV_CYC - 1);
	endproperty
	a_normal_len: assert property (p_normal_len) else $error("normal conversion length");

	property p_auto_len;
		@(posedge core_clk) disable iff (srst)
		(finish && !first_ff && auto_ff) |-> half_ff == 6'(2 * AUTO_CONV_CYC - 2);
	endproperty
	a_auto_len: assert property (p_auto_len) else $error("auto conversion length");

	// A trigger edge inside a conversion must not restart the prescaler
	property p_busy_keeps_presc;
		@(posedge core_clk) disable iff (srst)
		(busy_ff && converter_enable && presc_ff != mask) |=> presc_ff == $past(presc_ff) + 7'h01;
	endproperty
	a_busy_keeps_presc: assert property (p_busy_keeps_presc) else $error("prescaler restarted while busy");

	// Selections stay put while the converter is disabled
	property p_disabled_sel_held;
		@(posedge core_clk) disable iff (srst)
		!converter_enable |=> ($stable(active_channel) && $stable(active_reference));
	endproperty
	a_disabled_sel_held: assert property (p_disabled_sel_held) else $error("selection moved while off");

	// Free running keeps the start bit up across the restart
	property p_free_keeps_bit;
		@(posedge core_clk) disable iff (srst) restart |=> start_conversion_bit;
	endproperty
	a_free_keeps_bit: assert property (p_free_keeps_bit) else $error("start bit dropped in free run");
endmodule

// ---- dv/acs_analog_model.sv ----
// Behavioural model of the analog sample-and-hold and approximation array.
// Assumes the sequencer pulses sample_hold for one core cycle at the sample point.
`timescale 1ns/1ps
module acs_analog_model
	import acs_pkg::*;
(
	input  wire logic       core_clk,
	input  wire logic       srst,
	input  wire logic       sample_hold,
	input  wire logic       analog_enable,
	input  wire logic [3:0] active_channel,
	input  wire logic [5:0] input_level,
	output logic [9:0]      analog_result
);
	// Code is the channel sampled joined above the input level, so a wrong channel shows
	always_ff @(posedge core_clk) begin
		if (srst || !analog_enable) begin
			analog_result <= ~analog_result;
		end else if (sample_hold) begin
			analog_result <= {active_channel, input_level};
		end
	end
endmodule

// ---- dv/adc_conversion_sequencer_tb.sv ----
// Self-checking bench for the conversion sequencer with the analog array model.
// Assumes the design package is compiled first; runs from one 100 MHz clock.
`timescale 1ns/1ps
module adc_conversion_sequencer_tb;
	import acs_pkg::*;
	localparam int P = 4; // Core cycles per converter clock at prescale 2
	logic        clk = 0, srst = 1, poff = 1, en = 0, aen = 0, sw = 0, fclr = 0, lal = 0, lrd = 0, hrd = 0;
	logic [2:0]  tsel = 3'h0, psel = 3'h2; // Fast converter clock: resolution is not modelled
	logic [7:0]  trig = 8'h00;
	logic [3:0]  ch = 4'h0, och;
	logic [1:0]  rsel = 2'h0, oref;
	logic [5:0]  lvl = 6'h00;
	logic [9:0]  ares;
	logic [15:0] keep;
	logic [31:0] rs = 32'h0000_fd9e;
	wire         sbit, flag, sh, aon;
	wire  [7:0]  lo, hi;
	wire  [3:0]  ach;
	wire  [1:0]  reference_pin;
	int          errors = 0, n_tests = 0, n;
	acs_sequencer DUT (.core_clk(clk), .srst(srst), .converter_power_off(poff), .converter_enable(en),
		.auto_trigger_enable(aen), .trigger_source_select(tsel), .trigger_inputs(trig), .prescale_select(psel),
		.start_write(sw), .done_flag_clear(fclr), .channel_select(ch), .reference_select(rsel),
		.left_align_result(lal), .low_byte_read(lrd), .high_byte_read(hrd), .analog_result(ares),
		.start_conversion_bit(sbit), .conversion_done_flag(flag), .result_low_byte(lo), .result_high_byte(hi),
		.active_channel(ach), .active_reference(reference_pin), .sample_hold(sh), .analog_enable(aon));
	acs_analog_model u_ana (.core_clk(clk), .srst(srst), .sample_hold(sh), .analog_enable(aon),
		.active_channel(ach), .input_level(lvl), .analog_result(ares));
	// Free-running core clock
	initial begin
		forever #5 clk = ~clk;
	end
	function logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	// Expected data bytes for a code under either alignment
	function logic [15:0] exp_res(input logic [9:0] c, input logic l);
		return l ? {c, 6'h00} : {6'h00, c};
	endfunction
	task final_report;
		if (errors == 0 && n_tests > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_tests++;
		if (g !== e) begin
			errors++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Cycle counts land in a window, since the converter clock phase is free
	task chkr(input string nm, input int g, input int lo_b, input int hi_b);
		n_tests++;
		if (g < lo_b || g > hi_b) begin
			errors++;
			$display("Error %s expected %0d..%0d seen %0d", nm, lo_b, hi_b, g);
		end
	endtask
	task tk;
		@(posedge clk);
		#1;
	endtask
	task pulse(ref logic s);
		s = 1;
		tk;
		s = 0;
	endtask
	// Bounded wait for the done flag; the caller clears it
	task wflag(output int c);
		c = 1;
		while (flag !== 1'b1 && c < 3000) begin
			tk;
			c++;
		end
		if (c >= 3000) begin
			errors++;
			final_report;
		end
	endtask
	// Software start; channel moves to nch mid-conversion; returns length
	task conv(input logic [3:0] nch, output int c);
		och = ch;
		oref = rsel;
		pulse(sw);
		chk("start_bit_set", 1'b1, sbit);
		c = 1;
		while (sbit === 1'b1 && c < 3000) begin
			if (c == 2 * P) begin
				ch = nch;
				rsel = ~rsel;
			end
			if (c == 2 * P + 2) chk("frozen_reference", oref, reference_pin);
			tk;
			c++;
		end
		if (c >= 3000) begin
			errors++;
			final_report;
		end
		chk("done_flag", 1'b1, flag);
		chk("result", exp_res({och, lvl}, lal), {hi, lo});
		tk;
		chk("active_channel", nch, ach);
		chk("active_reference", rsel, reference_pin);
		pulse(fclr);
	endtask
	initial begin
		repeat (12) tk;
		srst = 0;
		en = 1;
		pulse(sw);
		repeat (2 * P) tk;
		chk("start_bit_off", 1'b0, sbit);
		poff = 0;
		tk;
		lvl = 6'h2b;
		conv(4'h5, n);
		chkr("first_len", n, 25 * P, 26 * P + 3);
		for (int i = 0; i < 6; i++) begin
			rs = xs(rs);
			lal = rs[0];
			lvl = rs[6:1];
			conv(rs[11:8], n);
			chkr("normal_len", n, 13 * P, 14 * P + 3);
		end
		// Low read locks data; flag still sets
		keep = {hi, lo};
		pulse(lrd);
		lvl = ~lvl;
		rsel = ~rsel; // Reference switch; this result is thrown away anyway
		pulse(sw);
		wflag(n);
		chk("locked_data", keep, {hi, lo});
		pulse(fclr);
		pulse(hrd);
		conv(ch, n);
		// Auto trigger from input 3; held level starts nothing more
		aen = 1;
		tsel = 3'h3;
		trig[3] = 1;
		repeat (TRIG_SYNC_CYC - 1) tk;
		chk("auto_sync", 1'b0, sbit);
		tk;
		chk("auto_start", 1'b1, sbit);
		repeat (P) tk;
		ch = ~och; // One converter clock after the trigger
		wflag(n);
		chkr("auto_len", n + P, 27 * P / 2, 27 * P / 2 + 2);
		chk("auto_result", exp_res({och, lvl}, lal), {hi, lo});
		pulse(fclr);
		repeat (20 * P) tk;
		chk("held_trig", 1'b0, sbit);
		trig[3] = 0;
		conv(ch, n);
		chkr("sw_in_auto", n, 13 * P, 14 * P + 3);
		// Free running: first start by software; channel moves after the first result
		tsel = TRIG_FREE_RUN;
		och = ch;
		pulse(sw);
		wflag(n);
		ch = ~och;
		pulse(fclr);
		chk("free_bit", 1'b1, sbit);
		wflag(n);
		chkr("free_gap", n, 13 * P - 2, 13 * P + 2);
		chk("free_old_channel", exp_res({och, lvl}, lal), {hi, lo});
		// Leaving auto mode lets the running conversion end the chain
		pulse(fclr);
		aen = 0;
		wflag(n);
		chk("free_new_channel", exp_res({~och, lvl}, lal), {hi, lo});
		chk("free_stop", 1'b0, sbit);
		pulse(fclr);
		// Disabled converter ignores selection changes
		en = 0;
		keep = {12'h000, ach};
		ch = ~ch;
		repeat (4) tk;
		chk("disabled_channel", keep, {12'h000, ach});
		// Re-enable at the fastest divider: first conversion is long again
		psel = 3'h0;
		en = 1;
		conv(4'h9, n);
		chkr("div2_first_len", n, 25 * 2, 26 * 2 + 3);
		final_report;
	end
endmodule
